// >>> verilog/ppr_top.v
`timescale 1ns/1ns
`include "ppr_defines.vh"
// dual 8-bit parallel port with bus register access and control lines
module ppr_top #(
    parameter WIDTH          = 8, // peripheral lines per port
    parameter AUX_B_ON_WRITE = 1  // port b aux handshake fires on data write, port a on data read
) (
    input  wire             ref_clk,
    input  wire             rst,
    // bus side
    input  wire             enable,
    input  wire             select_high_0,
    input  wire             select_high_1,
    input  wire             select_low_2_n,
    input  wire             reg_select_low,
    input  wire             reg_select_high,
    input  wire             read_not_write,
    input  wire [7:0]       data_in,
    output reg  [7:0]       data_out,
    output reg              data_oe_n,
    // open-drain requests: out is always low, oe_n low pulls the wire
    output reg              port_a_irq_n_out,
    output reg              port_a_irq_n_oe_n,
    output reg              port_b_irq_n_out,
    output reg              port_b_irq_n_oe_n,
    // peripheral side
    input  wire [WIDTH-1:0] port_a_lines_in,
    output reg  [WIDTH-1:0] port_a_lines_out,
    output reg  [WIDTH-1:0] port_a_lines_oe_n,
    input  wire [WIDTH-1:0] port_b_lines_in,
    output reg  [WIDTH-1:0] port_b_lines_out,
    output reg  [WIDTH-1:0] port_b_lines_oe_n,
    input  wire             port_a_edge_input,
    input  wire             port_b_edge_input,
    input  wire             port_a_aux_line_in,
    output reg              port_a_aux_line_out,
    output reg              port_a_aux_line_oe_n,
    input  wire             port_b_aux_line_in,
    output reg              port_b_aux_line_out,
    output reg              port_b_aux_line_oe_n
);
    // bus access captured during the enable pulse
    reg              e_q;         // enable delayed one cycle
    reg              acc_sel;     // device selected in this pulse
    reg  [1:0]       acc_rs;      // register select in this pulse
    reg              acc_rd;      // read_not_write in this pulse
    reg  [7:0]       acc_wdata;   // write data in this pulse
    // register file
    reg  [WIDTH-1:0] out_a;       // port a output register
    reg  [WIDTH-1:0] dir_a;       // port a direction
    reg  [5:0]       ctl_a;       // port a writable control bits
    reg  [WIDTH-1:0] out_b;
    reg  [WIDTH-1:0] dir_b;
    reg  [5:0]       ctl_b;
    // aux output handshake state
    reg              aux_a_lvl;
    reg              aux_b_lvl;
    reg              next_aux_a;
    reg              next_aux_b;
    // read path
    reg  [7:0]       next_rdata;
    wire             selected;
    wire             e_fall;
    wire [1:0]       live_rs;
    wire [WIDTH-1:0] pin_view_a;
    wire [WIDTH-1:0] pin_view_b;
    // flags and their handles, index 0 a-first, 1 a-aux, 2 b-first, 3 b-aux
    wire [3:0]       flag;
    wire [3:0]       line_vec;
    wire [3:0]       rise_vec;
    wire [3:0]       inmode_vec;
    wire [3:0]       clr_vec;
    wire             rd_a_data;
    wire             rd_b_data;
    wire             wr_b_data;
    wire             rearm;
    wire             irq_a;
    wire             irq_b;

    // selection needs both high selects and the low select
    assign selected = select_high_0 & select_high_1 & ~select_low_2_n;
    assign live_rs  = {reg_select_high, reg_select_low};
    // access completes on the trailing edge of enable
    assign e_fall   = e_q & ~enable;

    // enable history
    always @(posedge ref_clk) begin
        if (rst) begin
            e_q <= 1'b0;
        end else begin
            e_q <= enable;
        end
    end

    // the master keeps selects stable through the pulse, so the last
    // sample before the trailing edge stands for the whole access
    always @(posedge ref_clk) begin
        if (rst) begin
            acc_sel   <= 1'b0;
            acc_rs    <= 2'h0;
            acc_rd    <= 1'b0;
            acc_wdata <= `PPR_RST_BYTE;
        end else if (enable) begin
            acc_sel   <= selected;
            acc_rs    <= live_rs;
            acc_rd    <= read_not_write;
            acc_wdata <= data_in;
        end
    end

    // strobes derived from the completed access
    assign rd_a_data = e_fall & acc_sel & acc_rd & (acc_rs == `PPR_SEL_A_DATA) & ctl_a[`PPR_BIT_DATA_ACCESS];
    assign rd_b_data = e_fall & acc_sel & acc_rd & (acc_rs == `PPR_SEL_B_DATA) & ctl_b[`PPR_BIT_DATA_ACCESS];
    assign wr_b_data = e_fall & acc_sel & ~acc_rd & (acc_rs == `PPR_SEL_B_DATA) & ctl_b[`PPR_BIT_DATA_ACCESS];
    // any pulse spent deselected rearms every flag
    assign rearm     = e_fall & ~acc_sel;

    // register writes; flags are never a write target
    always @(posedge ref_clk) begin
        if (rst) begin
            out_a <= `PPR_RST_BYTE;
            dir_a <= `PPR_RST_BYTE;
            ctl_a <= `PPR_RST_CTRL;
            out_b <= `PPR_RST_BYTE;
            dir_b <= `PPR_RST_BYTE;
            ctl_b <= `PPR_RST_CTRL;
        end else if (e_fall && acc_sel && !acc_rd) begin
            // address decode over the six locations
            if (acc_rs == `PPR_SEL_A_DATA) begin
                if (ctl_a[`PPR_BIT_DATA_ACCESS]) begin
                    out_a <= acc_wdata[WIDTH-1:0];
                end else begin
                    dir_a <= acc_wdata[WIDTH-1:0];
                end
            end else if (acc_rs == `PPR_SEL_A_CTRL) begin
                ctl_a <= acc_wdata[5:0];
            end else if (acc_rs == `PPR_SEL_B_DATA) begin
                if (ctl_b[`PPR_BIT_DATA_ACCESS]) begin
                    out_b <= acc_wdata[WIDTH-1:0];
                end else begin
                    dir_b <= acc_wdata[WIDTH-1:0];
                end
            end else begin
                ctl_b <= acc_wdata[5:0];
            end
        end
    end

    // pins for inputs, own register for outputs
    assign pin_view_a = (port_a_lines_in & ~dir_a) | (out_a & dir_a);
    assign pin_view_b = (port_b_lines_in & ~dir_b) | (out_b & dir_b);

    // read multiplexer, decoded from the live selects
    always @* begin
        next_rdata = `PPR_RST_BYTE;
        if (live_rs == `PPR_SEL_A_DATA) begin
            if (ctl_a[`PPR_BIT_DATA_ACCESS]) begin
                next_rdata[WIDTH-1:0] = pin_view_a;
            end else begin
                next_rdata[WIDTH-1:0] = dir_a;
            end
        end else if (live_rs == `PPR_SEL_A_CTRL) begin
            next_rdata = {flag[0], flag[1], ctl_a};
        end else if (live_rs == `PPR_SEL_B_DATA) begin
            if (ctl_b[`PPR_BIT_DATA_ACCESS]) begin
                next_rdata[WIDTH-1:0] = pin_view_b;
            end else begin
                next_rdata[WIDTH-1:0] = dir_b;
            end
        end else begin
            next_rdata = {flag[2], flag[3], ctl_b};
        end
    end

    // data bus drive: registered, so it follows a selected read pulse one cycle late
    always @(posedge ref_clk) begin
        if (rst) begin
            data_out  <= `PPR_RST_BYTE;
            data_oe_n <= 1'b1;
        end else begin
            data_out  <= next_rdata;
            data_oe_n <= ~(enable & selected & read_not_write);
        end
    end

    // per-line control vectors for the flag cells
    assign line_vec   = {port_b_aux_line_in, port_b_edge_input, port_a_aux_line_in, port_a_edge_input};
    assign rise_vec   = {ctl_b[`PPR_BIT_AUX_EDGE], ctl_b[`PPR_BIT_FIRST_EDGE],
                         ctl_a[`PPR_BIT_AUX_EDGE], ctl_a[`PPR_BIT_FIRST_EDGE]};
    // first lines are always inputs; aux lines only while bit 5 is low
    assign inmode_vec = {~ctl_b[`PPR_BIT_AUX_OUT], 1'b1, ~ctl_a[`PPR_BIT_AUX_OUT], 1'b1};
    assign clr_vec    = {rd_b_data, rd_b_data, rd_a_data, rd_a_data};

    // one edge and flag cell per control line
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            ppr_edge_flag u_flag (
                .ref_clk     (ref_clk),
                .rst         (rst),
                .line_in     (line_vec[gi]),
                .edge_rising (rise_vec[gi]),
                .input_mode  (inmode_vec[gi]),
                .e_fall      (e_fall),
                .clear       (clr_vec[gi]),
                .rearm       (rearm),
                .flag        (flag[gi])
            );
        end
    endgenerate

    // request is a level of flag and enable, so a late enable still fires
    assign irq_a = (flag[0] & ctl_a[`PPR_BIT_FIRST_EN]) |
                   (flag[1] & ctl_a[`PPR_BIT_AUX_EN] & ~ctl_a[`PPR_BIT_AUX_OUT]);
    assign irq_b = (flag[2] & ctl_b[`PPR_BIT_FIRST_EN]) |
                   (flag[3] & ctl_b[`PPR_BIT_AUX_EN] & ~ctl_b[`PPR_BIT_AUX_OUT]);

    // open-drain request drivers
    always @(posedge ref_clk) begin
        if (rst) begin
            port_a_irq_n_out  <= 1'b0;
            port_a_irq_n_oe_n <= 1'b1;
            port_b_irq_n_out  <= 1'b0;
            port_b_irq_n_oe_n <= 1'b1;
        end else begin
            port_a_irq_n_out  <= 1'b0;
            port_a_irq_n_oe_n <= ~irq_a;
            port_b_irq_n_out  <= 1'b0;
            port_b_irq_n_oe_n <= ~irq_b;
        end
    end

    // aux output modes: bit 4 high gives a manual level equal to bit 3;
    // bit 4 low drops the line on a data access and raises it again on
    // a first-line flag (bit 3 low) or on the next enable fall (bit 3 high)
    always @* begin
        next_aux_a = aux_a_lvl;
        if (ctl_a[`PPR_BIT_AUX_EDGE]) begin
            next_aux_a = ctl_a[`PPR_BIT_AUX_EN];
        end else if (rd_a_data) begin
            next_aux_a = 1'b0;
        end else if (ctl_a[`PPR_BIT_AUX_EN] ? e_fall : flag[0]) begin
            next_aux_a = 1'b1;
        end
    end

    // port b variant differs only in the access that starts it
    always @* begin
        next_aux_b = aux_b_lvl;
        if (ctl_b[`PPR_BIT_AUX_EDGE]) begin
            next_aux_b = ctl_b[`PPR_BIT_AUX_EN];
        end else if (AUX_B_ON_WRITE ? wr_b_data : rd_b_data) begin
            next_aux_b = 1'b0;
        end else if (ctl_b[`PPR_BIT_AUX_EN] ? e_fall : flag[2]) begin
            next_aux_b = 1'b1;
        end
    end

    // aux state idles high so an input-to-output switch starts inactive
    always @(posedge ref_clk) begin
        if (rst) begin
            aux_a_lvl <= 1'b1;
            aux_b_lvl <= 1'b1;
        end else begin
            aux_a_lvl <= next_aux_a;
            aux_b_lvl <= next_aux_b;
        end
    end

    // peripheral pin drivers, all registered
    always @(posedge ref_clk) begin
        if (rst) begin
            port_a_lines_out     <= {WIDTH{1'b0}};
            port_a_lines_oe_n    <= {WIDTH{1'b1}};
            port_b_lines_out     <= {WIDTH{1'b0}};
            port_b_lines_oe_n    <= {WIDTH{1'b1}};
            port_a_aux_line_out  <= 1'b1;
            port_a_aux_line_oe_n <= 1'b1;
            port_b_aux_line_out  <= 1'b1;
            port_b_aux_line_oe_n <= 1'b1;
        end else begin
            port_a_lines_out     <= out_a;
            port_a_lines_oe_n    <= ~dir_a;
            port_b_lines_out     <= out_b;
            port_b_lines_oe_n    <= ~dir_b;
            port_a_aux_line_out  <= next_aux_a;
            port_a_aux_line_oe_n <= ~ctl_a[`PPR_BIT_AUX_OUT];
            port_b_aux_line_out  <= next_aux_b;
            port_b_aux_line_oe_n <= ~ctl_b[`PPR_BIT_AUX_OUT];
        end
    end
endmodule // ppr_top

// >>> include/ppr_defines.vh
// Overview of operation
// - six bus locations: data, direction, control
// - selects plus control bit 2 pick location
// - reset zeroes all registers, lines inputs
// - direction bit 0 input, 1 output
// - control bits 0-5 rw, 6-7 read-only
// - flags 7/6, aux field 5:3, access 2, edge 1:0
// - bus cannot set flags; data read clears
// - flag set by active edge on input line
// - bit 1 picks edge polarity of first line
// - bit 0 gates flag 7 onto request
// - late enable of bit 0 raises request
// - aux input: bit 4 edge, bit 3 enable
// - late enable of bit 3 raises request
// - bit 5 high makes aux line an output
// - cleared flag rearms only after deselected pulse
// - edge counts only after enable pulse conditioning
`ifndef PPR_DEFINES_VH
`define PPR_DEFINES_VH

// register select codes {reg_select_high, reg_select_low}
`define PPR_SEL_A_DATA      2'h0
`define PPR_SEL_A_CTRL      2'h1
`define PPR_SEL_B_DATA      2'h2
`define PPR_SEL_B_CTRL      2'h3

// control word field positions
`define PPR_BIT_FIRST_EN    0
`define PPR_BIT_FIRST_EDGE  1
`define PPR_BIT_DATA_ACCESS 2
`define PPR_BIT_AUX_EN      3
`define PPR_BIT_AUX_EDGE    4
`define PPR_BIT_AUX_OUT     5
`define PPR_BIT_AUX_FLAG    6
`define PPR_BIT_FIRST_FLAG  7

// reset values
`define PPR_RST_BYTE        8'h00
`define PPR_RST_CTRL        6'h00

`endif

// >>> verilog/ppr_edge_flag.v
`timescale 1ns/1ns
// one control line: edge sensing, conditioning and its sticky flag
module ppr_edge_flag (
    input  wire ref_clk,
    input  wire rst,
    input  wire line_in,      // sampled control line level
    input  wire edge_rising,  // 1 selects low-to-high as active
    input  wire input_mode,   // line programmed as an input
    input  wire e_fall,       // trailing edge of an enable pulse
    input  wire clear,        // read of this port's data register
    input  wire rearm,        // enable pulse seen while deselected
    output reg  flag          // sticky interrupt flag
);
    reg  line_q;   // previous line sample
    reg  armed;    // edge sense network conditioned
    reg  allow;    // flag may be set again after a clearing read
    wire active_edge;
    wire idle_level;
    wire set_flag;

    // active transition relative to the programmed polarity
    assign active_edge = edge_rising ? (line_in & ~line_q) : (~line_in & line_q);
    assign idle_level  = edge_rising ? ~line_in : line_in;
    // all three gates must agree before a flag can rise
    assign set_flag    = active_edge & armed & allow & input_mode;

    // line history
    always @(posedge ref_clk) begin
        if (rst) begin
            line_q <= 1'b1;
        end else begin
            line_q <= line_in;
        end
    end

    // conditioning: an enable pulse must fall while the line is idle
    always @(posedge ref_clk) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (active_edge) begin
            armed <= 1'b0;
        end else if (e_fall && idle_level) begin
            armed <= 1'b1;
        end
    end

    // rearm gate after a clearing read
    always @(posedge ref_clk) begin
        if (rst) begin
            allow <= 1'b1;
        end else if (clear) begin
            allow <= 1'b0;
        end else if (rearm) begin
            allow <= 1'b1;
        end
    end

    // sticky flag; a set in the clearing cycle wins so no event is lost
    always @(posedge ref_clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_flag) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule // ppr_edge_flag

// >>> testbench/ppr_top_properties.sv
`timescale 1ns/1ns
// pin-level timing checks of the bus strobe, pins and requests
module ppr_top_properties (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       enable,
    input wire logic       select_high_0,
    input wire logic       select_high_1,
    input wire logic       select_low_2_n,
    input wire logic       read_not_write,
    input wire logic       data_oe_n,
    input wire logic       port_a_irq_n_out,
    input wire logic       port_a_irq_n_oe_n,
    input wire logic       port_b_irq_n_out,
    input wire logic       port_b_irq_n_oe_n,
    input wire logic [7:0] port_a_lines_oe_n,
    input wire logic       port_a_edge_input,
    input wire logic       port_b_edge_input,
    input wire logic       port_a_aux_line_in,
    input wire logic       port_b_aux_line_in,
    input wire logic       port_a_aux_line_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [2:0] en_age;   // cycles since strobe high
    logic [2:0] ln_age;   // cycles since a control line moved
    logic [3:0] ln_prev;  // control lines one cycle ago
    wire        sel = select_high_0 && select_high_1 && !select_low_2_n;
    wire [3:0]  ln_now = {port_a_edge_input, port_a_aux_line_in, port_b_edge_input, port_b_aux_line_in};
    // saturating ages: pins and requests may only move shortly after a cause
    always @(posedge ref_clk) begin
        ln_prev <= ln_now;
        en_age <= rst ? 3'h7 : enable ? 3'h0 : en_age + {2'h0, en_age != 3'h7};
        ln_age <= rst ? 3'h7 : (ln_now != ln_prev) ? 3'h0 : ln_age + {2'h0, ln_age != 3'h7};
    end
    sequence e_fall_s;  // an access completes
        enable ##1 !enable;
    endsequence
    sequence bus_idle_s;  // strobe low two samples running
        !enable ##1 !enable;
    endsequence
    reset_idle_a: assert property ($fell(rst) |-> data_oe_n && port_a_irq_n_oe_n && port_b_irq_n_oe_n
        && &port_a_lines_oe_n && port_a_aux_line_oe_n) else $error("outputs not idle after reset");
    read_drive_a: assert property (enable && sel && read_not_write |=> !data_oe_n)
        else $error("bus not driven on read");
    read_quiet_a: assert property (bus_idle_s |-> data_oe_n) else $error("bus driven while idle");
    read_end_a: assert property (e_fall_s |=> data_oe_n) else $error("bus held after access");
    desel_quiet_a: assert property (!sel |=> data_oe_n) else $error("bus driven while deselected");
    pins_follow_a: assert property ($changed(port_a_lines_oe_n) |-> en_age <= 3'h4)
        else $error("direction moved without write");
    aux_dir_a: assert property ($changed(port_a_aux_line_oe_n) |-> en_age <= 3'h4)
        else $error("aux direction moved without write");
    irq_a_cause_a: assert property ($fell(port_a_irq_n_oe_n) |-> en_age <= 3'h4 || ln_age <= 3'h4)
        else $error("request a without cause");
    irq_b_cause_a: assert property ($fell(port_b_irq_n_oe_n) |-> en_age <= 3'h4 || ln_age <= 3'h4)
        else $error("request b without cause");
    irq_release_a: assert property ($rose(port_a_irq_n_oe_n) || $rose(port_b_irq_n_oe_n) |-> en_age <= 3'h4)
        else $error("request released without access");
    drain_low_a: assert property (!port_a_irq_n_out && !port_b_irq_n_out) else $error("request pin not low");
endmodule // ppr_top_properties
bind ppr_top ppr_top_properties i_ppr_top_properties (
    .ref_clk(ref_clk), .rst(rst), .enable(enable), .select_high_0(select_high_0),
    .select_high_1(select_high_1), .select_low_2_n(select_low_2_n), .read_not_write(read_not_write),
    .data_oe_n(data_oe_n), .port_a_irq_n_out(port_a_irq_n_out), .port_a_irq_n_oe_n(port_a_irq_n_oe_n),
    .port_b_irq_n_out(port_b_irq_n_out), .port_b_irq_n_oe_n(port_b_irq_n_oe_n),
    .port_a_lines_oe_n(port_a_lines_oe_n[7:0]), .port_a_edge_input(port_a_edge_input),
    .port_b_edge_input(port_b_edge_input), .port_a_aux_line_in(port_a_aux_line_in),
    .port_b_aux_line_in(port_b_aux_line_in), .port_a_aux_line_oe_n(port_a_aux_line_oe_n));

// >>> testbench/ppr_periph_model.sv
`timescale 1ns/1ns
// peripheral side: drives every data and aux line the block leaves undriven
module ppr_periph_model (
    input  wire logic [7:0] offer_a,   // peripheral levels, port a
    input  wire logic [7:0] offer_b,   // peripheral levels, port b
    input  wire logic       aux_off_a, // peripheral aux level, port a
    input  wire logic       aux_off_b, // peripheral aux level, port b
    input  wire logic [7:0] out_a,
    input  wire logic [7:0] oe_n_a,    // low where the block drives
    input  wire logic [7:0] out_b,
    input  wire logic [7:0] oe_n_b,
    input  wire logic       aux_out_a,
    input  wire logic       aux_oe_n_a,
    input  wire logic       aux_out_b,
    input  wire logic       aux_oe_n_b,
    output wire logic [7:0] wire_a,    // resolved levels fed back
    output wire logic [7:0] wire_b,
    output wire logic       aux_wire_a,
    output wire logic       aux_wire_b
);
    // the block wins where it drives, the peripheral elsewhere
    assign wire_a = (out_a & ~oe_n_a) | (offer_a & oe_n_a);
    assign wire_b = (out_b & ~oe_n_b) | (offer_b & oe_n_b);
    assign aux_wire_a = aux_oe_n_a ? aux_off_a : aux_out_a;
    assign aux_wire_b = aux_oe_n_b ? aux_off_b : aux_out_b;
endmodule // ppr_periph_model

// >>> testbench/tb_parallel_port_register_control.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
// bus master, peripheral and register reference against the block
module tb_parallel_port_register_control;
    logic        ref_clk = 0;
    logic        rst = 1;
    logic        en = 0, rnw = 1, s0 = 0, s1 = 0, s2n = 1;  // strobe, direction, selects
    logic [1:0]  rs = 0;                  // register select pair
    logic [7:0]  din = 0, dout, q;        // bus data and last read
    logic        doe_n, ia, ia_oe, ib, ib_oe;
    logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic        ax_in, ax_out, ax_oe, bx_in, bx_out, bx_oe;
    logic [7:0]  ext [2] = '{8'h00, 8'h00};  // peripheral offered levels
    logic        cl [2] = '{1'b1, 1'b1};     // first control lines
    logic        xl [2] = '{1'b1, 1'b1};     // offered aux levels
    int          ctl [2], ddr [2], outr [2], f1 [2], f2 [2];  // reference registers
    int          errors = 0, checks = 0, cyc = 0, p, ln, pol, ie, c;
    logic [31:0] r = 32'h0000_ef56;        // lfsr state
    initial forever #50 ref_clk = ~ref_clk;
    ppr_top i_ppr_top (.ref_clk(ref_clk), .rst(rst), .enable(en), .select_high_0(s0), .select_high_1(s1),
        .select_low_2_n(s2n), .reg_select_low(rs[0]), .reg_select_high(rs[1]), .read_not_write(rnw),
        .data_in(din), .data_out(dout), .data_oe_n(doe_n), .port_a_irq_n_out(ia), .port_a_irq_n_oe_n(ia_oe),
        .port_b_irq_n_out(ib), .port_b_irq_n_oe_n(ib_oe), .port_a_lines_in(pa_in), .port_a_lines_out(pa_out),
        .port_a_lines_oe_n(pa_oe), .port_b_lines_in(pb_in), .port_b_lines_out(pb_out), .port_b_lines_oe_n(pb_oe),
        .port_a_edge_input(cl[0]), .port_b_edge_input(cl[1]), .port_a_aux_line_in(ax_in),
        .port_a_aux_line_out(ax_out), .port_a_aux_line_oe_n(ax_oe), .port_b_aux_line_in(bx_in),
        .port_b_aux_line_out(bx_out), .port_b_aux_line_oe_n(bx_oe));
    ppr_periph_model i_ppr_periph_model (.offer_a(ext[0]), .offer_b(ext[1]), .aux_off_a(xl[0]),
        .aux_off_b(xl[1]), .out_a(pa_out), .oe_n_a(pa_oe), .out_b(pb_out), .oe_n_b(pb_oe), .aux_out_a(ax_out),
        .aux_oe_n_a(ax_oe), .aux_out_b(bx_out), .aux_oe_n_b(bx_oe), .wire_a(pa_in), .wire_b(pb_in),
        .aux_wire_a(ax_in), .aux_wire_b(bx_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference view of a location: control, data merge or direction
    function automatic logic [7:0] exp_rd(input int a);
        int k = a / 2;
        if (a % 2)
            return {f1[k][0], f2[k][0], ctl[k][5:0]};
        if (ctl[k][2])
            return (ext[k] & ~ddr[k][7:0]) | (outr[k][7:0] & ddr[k][7:0]);
        return ddr[k][7:0];
    endfunction
    task automatic step(input int n);  // leave the edge before driving
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one strobe; selects held until the closing edge has been sampled
    task automatic bus(input int a, input logic w, input int d, input logic s);
        {rs, rnw, din, s0, s1, s2n, en} = {a[1:0], w, d[7:0], s, s, !s, 1'b1};
        step(2);
        q = dout;
        en = 0;
        step(1);
    endtask
    task automatic wr(input int a, input int d);
        bus(a, 0, d, 1);
        if (a % 2)
            ctl[a/2] = d & 63;
        else if (ctl[a/2][2])
            outr[a/2] = d;
        else
            ddr[a/2] = d;
    endtask
    task automatic rd(input int a);
        bus(a, 1, 0, 1);
        `CHK(q, exp_rd(a))
        if (a % 2 == 0 && ctl[a/2][2])
            {f1[a/2], f2[a/2]} = 0;
    endtask
    task automatic chk_irq(input int k);  // request level from reference flags and enables
        logic e;
        e = (f1[k][0] && ctl[k][0]) || (f2[k][0] && ctl[k][3] && !ctl[k][5]);
        `CHK(k ? ib_oe : ia_oe, !e)
    endtask
    task automatic setln(input int k, input int aux, input logic v);
        if (aux)
            xl[k] = v;
        else
            cl[k] = v;
    endtask
    task automatic do_reset();
        rst = 1;
        step(6);
        rst = 0;
        foreach (ctl[i]) {ctl[i], ddr[i], outr[i], f1[i], f2[i]} = 0;
        for (int a = 0; a < 4; a++) rd(a);
        `CHK({pa_oe, pb_oe, ax_oe, bx_oe, ia_oe, ib_oe}, {20{1'b1}})
        $display("test reset done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard: the whole run needs only about 600 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        do_reset();
        for (int i = 0; i < 6; i++) begin  // random directions, outputs and pins
            p = i % 2;
            r = lfsr(r);
            ext[p] = r[7:0];
            wr(2*p+1, 0);
            wr(2*p, r[15:8]);
            wr(2*p+1, 4);
            wr(2*p, r[23:16]);
            rd(2*p);
            `CHK(p ? pb_oe : pa_oe, ~ddr[p][7:0])
            `CHK(p ? pb_out : pa_out, outr[p][7:0])
            wr(2*p+1, 247);  // aux output at a manual low level
            step(1);
            `CHK(p ? bx_out : ax_out, 1'b0)
            wr(2*p+1, 255);
            rd(2*p+1);
            `CHK(p ? bx_oe : ax_oe, 1'b0)
            `CHK(p ? bx_out : ax_out, 1'b1)
        end
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin  // every line, edge and enable
            p = i / 8;
            ln = i / 4 % 2;
            pol = i / 2 % 2;
            ie = i % 2;
            c = 4 | (ln ? pol*16 + ie*8 : pol*2 + ie);
            setln(p, ln, !pol);
            wr(2*p+1, c);
            rd(2*p);
            bus(0, 1, 0, 0);  // deselected strobe rearms at the idle level
            setln(p, ln, pol);
            step(4);
            if (ln)
                f2[p] = 1;
            else
                f1[p] = 1;
            rd(2*p+1);
            chk_irq(p);
            if (!ie) begin
                wr(2*p+1, c | (ln ? 8 : 1));
                step(2);
                chk_irq(p);
            end
            rd(2*p);
            step(2);
            chk_irq(p);
        end
        $display("test edges done");
        wr(1, 4);
        bus(0, 1, 0, 0);
        setln(0, 0, 0);
        step(4);
        f1[0] = 1;
        rd(1);
        rd(0);
        setln(0, 0, 1);
        wr(1, 4);  // selected strobe only: no rearm
        setln(0, 0, 0);
        step(4);
        rd(1);
        bus(0, 1, 0, 0);
        setln(0, 0, 1);
        step(1);
        setln(0, 0, 0);  // no strobe between inactive and active edge
        step(4);
        rd(1);
        $display("test rearm done");
        do_reset();
        test_done();
    end
endmodule // tb_parallel_port_register_control
